// ---- bench/power_pad_control_regs_bench.sv ----
// Self-checking bench for the power and pad control register bank.
`timescale 1ns/1ps

module power_pad_control_regs_bench;
	logic                        pclk = 1'b0;
	logic                        presetn = 1'b0;
	logic                        psel = 1'b0;
	logic                        penable = 1'b0;
	logic                        pwrite = 1'b0;
	logic [31:0]                 paddr = 32'h0;
	logic [31:0]                 pwdata = 32'h0;
	logic [31:0]                 prdata;
	logic                        pready;
	logic                        pslverr;
	logic                        wake_pin_in = 1'b0;
	logic                        wake_pin_out;
	logic                        wake_pin_oe;
	logic                        idle_wake;
	logic                        rtc_alarm = 1'b0;
	logic                        core_regulator_enable_pin_n = 1'b0;
	logic                        clock_source_select_pin = 1'b1;
	logic                        rtc_clock_out_enable;
	logic                        core_regulator_voltage_select;
	logic                        usb_regulator_enable;
	power_pad_pkg::power_state_t power_state;
	power_pad_pkg::pad_control_t pad_control;
	logic [32:0]                 exp_q[$];
	logic [31:0]                 d;
	int                          mismatches = 0;
	int                          n_checks = 0;
	logic [31:0] addr_tab[5] = '{32'h0000_64C0, 32'h0000_7058, 32'h0000_705C, 32'h0000_7060, 32'h0001_C010};
	logic [15:0] mask_tab[5] = '{16'h001F, 16'h0005, 16'h3F3F, 16'hFFFF, 16'h0003};
	logic [15:0] rst_tab[5]  = '{16'h0010, 16'h0005, 16'h3F3F, 16'hF03F, 16'h0000};

	power_pad_control_regs u_power_pad_control_regs (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .wake_pin_in, .wake_pin_out, .wake_pin_oe, .idle_wake, .rtc_alarm,
		.core_regulator_enable_pin_n, .clock_source_select_pin, .rtc_clock_out_enable,
		.core_regulator_voltage_select, .usb_regulator_enable, .power_state, .pad_control);

	always #5 pclk = ~pclk;

	task automatic cmp(input string name, input logic [32:0] e, input logic [32:0] g);
		n_checks++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", name, e, g);
		end
	endtask : cmp

	always @(posedge pclk) begin
		if (psel && penable && pready) begin
			cmp("apb answer", exp_q.pop_front(), {pslverr, prdata});
		end
	end

	task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd, input logic [32:0] e);
		@(posedge pclk);
		exp_q.push_back(e);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input int i, input logic [31:0] wd);
		apb(1'b1, addr_tab[i], wd, 33'h0);
	endtask : wr

	task automatic rd(input int i, input logic [15:0] v);
		apb(1'b0, addr_tab[i], 32'h0, {17'h0, v});
	endtask : rd

	task automatic settle;
		repeat (2) @(posedge pclk);
		#1;
	endtask : settle

	task automatic do_reset(input logic s);
		presetn                 <= 1'b0;
		clock_source_select_pin <= s;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		settle;
	endtask : do_reset

	task automatic alarm;
		rtc_alarm <= 1'b1;
		@(posedge pclk);
		rtc_alarm <= 1'b0;
		settle;
	endtask : alarm

	task automatic test_done;
		if (mismatches == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : test_done

	initial begin
		repeat (3000) @(posedge pclk);
		mismatches++;
		test_done;
	end

	initial begin
		void'($urandom(48));
		do_reset(1'b1);
		apb(1'b1, 32'h0000_7064, 32'hFFFF_FFFF, {1'b1, 32'h0});
		apb(1'b0, 32'h0000_64C4, 32'h0, {1'b1, 32'h0});
		for (int i = 0; i < 5; i++) rd(i, rst_tab[i]);
		for (int i = 0; i < 5; i++) begin
			d = $urandom;
			if (i == 0) d = d & 32'hFFFF_FFF9;
			wr(i, d);
			rd(i, d[15:0] & mask_tab[i]);
		end
		wr(0, 32'h0000_0009);
		wake_pin_in <= 1'b1;
		settle;
		cmp("wake out", 4'b1001, {wake_pin_oe, wake_pin_out, idle_wake, rtc_clock_out_enable});
		wr(0, 32'h0000_0000);
		settle;
		cmp("wake in", 4'b0010, {wake_pin_oe, wake_pin_out, idle_wake, rtc_clock_out_enable});
		wr(4, 32'h0000_0002);
		wr(1, 32'h0000_0000);
		wr(2, 32'hFFFF_D2F4);
		wr(3, 32'h0000_5A5A);
		settle;
		cmp("voltage", 1'b1, core_regulator_voltage_select);
		cmp("pads", 3'b001, pad_control[34:32]);
		cmp("pull inhibit", 32'h1234_5A5A, pad_control[31:0]);
		cmp("power", 5'b11011, power_state);
		core_regulator_enable_pin_n <= 1'b1;
		settle;
		cmp("core pin", 5'b10011, power_state);
		core_regulator_enable_pin_n <= 1'b0;
		wr(4, 32'h0000_0001);
		settle;
		cmp("usb on", 7'b0111111, {core_regulator_voltage_select, usb_regulator_enable, power_state});
		wr(0, 32'h0000_000C);
		settle;
		cmp("full off", 6'b000000, {usb_regulator_enable, power_state});
		alarm;
		cmp("alarm", 5'b11111, power_state);
		rd(0, 16'h0008);
		wake_pin_in <= 1'b0;
		wr(0, 32'h0000_0002);
		settle;
		cmp("ldo off", 5'b00001, power_state);
		wake_pin_in <= 1'b1;
		settle;
		cmp("pin wake", 5'b11111, power_state);
		wake_pin_in <= 1'b0;
		do_reset(1'b0);
		rd(4, 16'h0001);
		wr(4, 32'h0000_0000);
		settle;
		cmp("usb held", 2'b11, {usb_regulator_enable, power_state.usb_regulator_on});
		wr(0, 32'h0000_0004);
		settle;
		cmp("usb shut", 2'b00, {usb_regulator_enable, power_state.usb_regulator_on});
		repeat (3) @(posedge pclk);
		test_done;
	end
endmodule : power_pad_control_regs_bench

// ---- bench/power_pad_properties.sv ----
// Concurrent checks on the ports of the power and pad control register bank.
`timescale 1ns/1ps

module power_pad_checks #(
	parameter int ADDR_W = 32
) (
	input wire logic                        pclk,
	input wire logic                        presetn,
	input wire logic                        psel,
	input wire logic                        penable,
	input wire logic                        pwrite,
	input wire logic [ADDR_W-1:0]           paddr,
	input wire logic [31:0]                 pwdata,
	input wire logic [31:0]                 prdata,
	input wire logic                        pready,
	input wire logic                        pslverr,
	input wire logic                        wake_pin_in,
	input wire logic                        wake_pin_out,
	input wire logic                        wake_pin_oe,
	input wire logic                        idle_wake,
	input wire logic                        rtc_alarm,
	input wire logic                        core_regulator_enable_pin_n,
	input wire power_pad_pkg::power_state_t power_state,
	input wire power_pad_pkg::pad_control_t pad_control
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire logic pm_write = psel && penable && pready && pwrite && paddr == ADDR_W'(32'h0000_64C0);

	sequence shut_seen;
		!power_state.analog_regulator_on && !psel;
	endsequence
	sequence alarm_seen;
		rtc_alarm;
	endsequence

	chk_ready_next: assert property (psel && !penable |=> pready)
		else $error("pready missing after setup");
	chk_err_ready: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
		else $error("error answer malformed");
	chk_read_upper: assert property (pready |-> prdata[31:16] == 16'h0000)
		else $error("upper read bits not zero");
	chk_wake_oe: assert property (pm_write |=> wake_pin_oe == ($past(pwdata[3]) && !$past(pwdata[4])) && !wake_pin_out)
		else $error("wake pin drive wrong");
	chk_dir_block: assert property (wake_pin_oe |=> !idle_wake)
		else $error("wake accepted while output");
	chk_wake_level: assert property (!wake_pin_in |=> !idle_wake)
		else $error("wake seen on low pin");
	chk_full_off: assert property (!power_state.bandgap_on |-> power_state == 5'h00)
		else $error("circuit on during full shutdown");
	chk_ldo_off: assert property (!power_state.analog_por_on |-> power_state[4:2] == 3'h0)
		else $error("regulator on during shutdown");
	chk_wake_back: assert property (shut_seen ##0 alarm_seen |-> ##[1:2] power_state.analog_regulator_on)
		else $error("alarm did not restore power");
	chk_core_pin: assert property ($past(core_regulator_enable_pin_n) |-> !power_state.core_regulator_on)
		else $error("core regulator on with pin high");
	chk_pads_fixed: assert property (pad_control.test_reset_n_pin_pulldown_en
		&& pad_control.serial_pulldown_inhibit[15:14] == 2'h0)
		else $error("fixed pad bits wrong");
endmodule : power_pad_checks

bind power_pad_control_regs power_pad_checks #(.ADDR_W(ADDR_W)) u_power_pad_checks (.pclk, .presetn, .psel,
	.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .wake_pin_in, .wake_pin_out, .wake_pin_oe,
	.idle_wake, .rtc_alarm, .core_regulator_enable_pin_n, .power_state, .pad_control);

// ---- verilog/power_pad_control_regs.sv ----
// APB register bank that drives wake pin, regulator power-down, voltage select and pad controls.
`timescale 1ns/1ps

module power_pad_control_regs #(
	parameter int ADDR_W = 32
) (
	input  wire logic                       pclk,
	input  wire logic                       presetn,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [ADDR_W-1:0]          paddr,
	input  wire logic [31:0]                pwdata,
	output logic [31:0]                     prdata,
	output logic                            pready,
	output logic                            pslverr,
	input  wire logic                       wake_pin_in,
	output logic                            wake_pin_out,
	output logic                            wake_pin_oe,
	output logic                            idle_wake,
	input  wire logic                       rtc_alarm,
	input  wire logic                       core_regulator_enable_pin_n,
	input  wire logic                       clock_source_select_pin,
	output logic                            rtc_clock_out_enable,
	output logic                            core_regulator_voltage_select,
	output logic                            usb_regulator_enable,
	output power_pad_pkg::power_state_t     power_state,
	output power_pad_pkg::pad_control_t     pad_control
);

	// Byte address of a register: four times its printed index.
	function automatic logic [ADDR_W-1:0] byte_addr(input logic [15:0] idx);
		logic [ADDR_W-1:0] a;
		a = '0;
		a[17:0] = {idx, 2'b00};
		return a;
	endfunction : byte_addr

	// Masked update that leaves reserved and read-only bits untouched.
	function automatic logic [15:0] merge_write(
		input logic [15:0] old_val,
		input logic [15:0] wdata,
		input logic [15:0] mask
	);
		return (old_val & ~mask) | (wdata & mask);
	endfunction : merge_write

	logic [15:0] pmgt_reg;
	logic [15:0] pmgt_next;
	logic [15:0] slew_reg;
	logic [15:0] pud1_reg;
	logic [15:0] pud2_reg;
	logic [15:0] ldo_reg;
	logic [15:0] ldo_next;
	logic        strap_done_reg;
	logic        clk_sel_low_reg;
	logic [31:0] prdata_next;

	wire logic        setup_phase = psel & ~penable;
	wire logic        access_done = psel & penable & pready;
	wire logic        wr_strobe   = access_done & pwrite;
	wire logic [15:0] wdata16     = pwdata[15:0];

	wire logic hit_pmgt = paddr == byte_addr(power_pad_pkg::RTC_POWER_MANAGEMENT_IDX);
	wire logic hit_slew = paddr == byte_addr(power_pad_pkg::OUTPUT_SLEW_CONTROL_IDX);
	wire logic hit_pud1 = paddr == byte_addr(power_pad_pkg::SERIAL_PULLDOWN_INHIBIT_IDX);
	wire logic hit_pud2 = paddr == byte_addr(power_pad_pkg::MISC_PULL_INHIBIT_IDX);
	wire logic hit_ldo  = paddr == byte_addr(power_pad_pkg::REGULATOR_CONTROL_IDX);
	wire logic hit_any  = hit_pmgt | hit_slew | hit_pud1 | hit_pud2 | hit_ldo;

	wire logic wr_pmgt = wr_strobe & hit_pmgt; // R20
	wire logic wr_slew = wr_strobe & hit_slew; // R20
	wire logic wr_pud1 = wr_strobe & hit_pud1; // R20
	wire logic wr_pud2 = wr_strobe & hit_pud2; // R20
	wire logic wr_ldo  = wr_strobe & hit_ldo;  // R20

	// Field views of the stored registers.
	wire logic wake_drive    = pmgt_reg[power_pad_pkg::WAKE_PIN_DRIVE_BIT];
	wire logic wake_dir_out  = pmgt_reg[power_pad_pkg::WAKE_PIN_DIRECTION_BIT];
	wire logic full_shutdown = pmgt_reg[power_pad_pkg::FULL_ANALOG_SHUTDOWN_BIT];
	wire logic reg_shutdown  = pmgt_reg[power_pad_pkg::REGULATOR_SHUTDOWN_BIT];
	wire logic usb_bit       = ldo_reg[power_pad_pkg::USB_REGULATOR_ENABLE_BIT];
	wire logic core_v_bit    = ldo_reg[power_pad_pkg::CORE_VOLTAGE_SELECT_BIT];

	// Wake pin counts as a wake source only when configured as an active-high input.
	wire logic wake_seen     = ~wake_dir_out & wake_pin_in; // R4 R5
	wire logic any_shutdown  = full_shutdown | reg_shutdown; // R6 R7
	wire logic reenable      = any_shutdown & (wake_seen | rtc_alarm); // R8

	// Power state derived from shutdown bits, core enable pin, USB enable bit and strap.
	wire logic analog_on_next = ~any_shutdown; // R6 R7
	wire logic por_on_next    = ~any_shutdown; // R6 R7
	wire logic bandgap_next   = ~full_shutdown; // R6 R7
	wire logic core_on_next   = ~any_shutdown & ~core_regulator_enable_pin_n; // R14
	wire logic usb_on_next    = ~any_shutdown & (clk_sel_low_reg | usb_bit); // R12 R15

	// A wake clears both shutdown bits; a write in the same cycle takes priority.
	always_comb begin
		pmgt_next = pmgt_reg;
		if (reenable) begin
			pmgt_next[power_pad_pkg::FULL_ANALOG_SHUTDOWN_BIT] = 1'b0; // R8
			pmgt_next[power_pad_pkg::REGULATOR_SHUTDOWN_BIT]   = 1'b0; // R8
		end
		if (wr_pmgt) begin
			pmgt_next = merge_write(pmgt_reg, wdata16, power_pad_pkg::RTC_POWER_MANAGEMENT_MASK); // R1
		end
	end

	// The strap is caught on the first edge after reset release.
	always_comb begin
		ldo_next = ldo_reg;
		if (!strap_done_reg) begin
			ldo_next[power_pad_pkg::USB_REGULATOR_ENABLE_BIT] = ~clock_source_select_pin; // R13
		end
		if (wr_ldo) begin
			ldo_next = merge_write(ldo_next, wdata16, power_pad_pkg::REGULATOR_CONTROL_MASK); // R1
		end
	end

	// Read multiplexer with reserved bits forced to zero.
	always_comb begin
		prdata_next = power_pad_pkg::UNMAPPED_READ_VALUE;
		if (hit_pmgt) begin
			prdata_next[15:0] = pmgt_reg & power_pad_pkg::RTC_POWER_MANAGEMENT_MASK; // R1
		end
		if (hit_slew) begin
			prdata_next[15:0] = slew_reg & power_pad_pkg::OUTPUT_SLEW_CONTROL_MASK;
		end
		if (hit_pud1) begin
			prdata_next[15:0] = pud1_reg & power_pad_pkg::SERIAL_PULLDOWN_INHIBIT_MASK;
		end
		if (hit_pud2) begin
			prdata_next[15:0] = pud2_reg & power_pad_pkg::MISC_PULL_INHIBIT_MASK;
		end
		if (hit_ldo) begin
			prdata_next[15:0] = ldo_reg & power_pad_pkg::REGULATOR_CONTROL_MASK; // R1
		end
	end

	// Bus answer: one wait-free access phase after every setup cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= setup_phase;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= setup_phase & ~hit_any;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (setup_phase) begin
			prdata <= pwrite ? 32'h0000_0000 : prdata_next;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pmgt_reg <= power_pad_pkg::RTC_POWER_MANAGEMENT_RESET; // R3 R10 R20
		end else begin
			pmgt_reg <= pmgt_next;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slew_reg <= power_pad_pkg::OUTPUT_SLEW_CONTROL_RESET; // R16 R17
		end else if (wr_slew) begin
			slew_reg <= merge_write(slew_reg, wdata16, power_pad_pkg::OUTPUT_SLEW_CONTROL_MASK);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pud1_reg <= power_pad_pkg::SERIAL_PULLDOWN_INHIBIT_RESET; // R18
		end else if (wr_pud1) begin
			pud1_reg <= merge_write(pud1_reg, wdata16, power_pad_pkg::SERIAL_PULLDOWN_INHIBIT_MASK); // R18
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pud2_reg <= power_pad_pkg::MISC_PULL_INHIBIT_RESET;
		end else if (wr_pud2) begin
			pud2_reg <= merge_write(pud2_reg, wdata16, power_pad_pkg::MISC_PULL_INHIBIT_MASK);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ldo_reg <= power_pad_pkg::REGULATOR_CONTROL_RESET; // R11
		end else begin
			ldo_reg <= ldo_next;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strap_done_reg  <= 1'b0;
			clk_sel_low_reg <= 1'b0;
		end else if (!strap_done_reg) begin
			strap_done_reg  <= 1'b1;
			clk_sel_low_reg <= ~clock_source_select_pin; // R13 R15
		end
	end

	// Open-drain wake output: enable only to pull low.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_pin_out <= 1'b0;
			wake_pin_oe  <= 1'b0;
		end else begin
			wake_pin_out <= 1'b0; // R2 R4
			wake_pin_oe  <= pmgt_next[power_pad_pkg::WAKE_PIN_DIRECTION_BIT] &
			                ~pmgt_next[power_pad_pkg::WAKE_PIN_DRIVE_BIT]; // R2 R3 R4
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idle_wake <= 1'b0;
		end else begin
			idle_wake <= wake_seen; // R5
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rtc_clock_out_enable          <= 1'b0;
			core_regulator_voltage_select <= 1'b0;
			usb_regulator_enable          <= 1'b0;
		end else begin
			rtc_clock_out_enable          <= pmgt_reg[power_pad_pkg::RTC_CLOCK_OUT_ENABLE_BIT]; // R10
			core_regulator_voltage_select <= core_v_bit; // R11
			usb_regulator_enable          <= usb_on_next; // R12 R15
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			power_state <= power_pad_pkg::POWER_STATE_RESET;
		end else begin
			power_state.analog_regulator_on <= analog_on_next; // R6 R7
			power_state.core_regulator_on   <= core_on_next; // R14
			power_state.usb_regulator_on    <= usb_on_next; // R15
			power_state.analog_por_on       <= por_on_next; // R6 R7
			power_state.bandgap_on          <= bandgap_next; // R6 R7
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pad_control <= power_pad_pkg::PAD_CONTROL_RESET;
		end else begin
			pad_control.clock_out_slew_select <= slew_reg[power_pad_pkg::CLOCK_OUT_SLEW_SELECT_BIT]; // R16
			pad_control.ext_mem_slew_select   <= slew_reg[power_pad_pkg::EXT_MEM_SLEW_SELECT_BIT]; // R17
			pad_control.test_reset_n_pin_pulldown_en <= 1'b1; // R19
			pad_control.serial_pulldown_inhibit <= pud1_reg & power_pad_pkg::SERIAL_PULLDOWN_INHIBIT_MASK; // R18
			pad_control.misc_pull_inhibit       <= pud2_reg;
		end
	end

endmodule : power_pad_control_regs

// ---- verilog/power_pad_pkg.sv ----
// Package with register map, field layout, reset values and shared types for the power and pad control bank.
// Notes on behaviour
// (R1) Reserved bits of power management and regulator control read zero, writes ignored.
// (R2) Wake drive bit 4: zero pulls wake pin low, one releases it.
// (R3) Wake direction bit 3: zero input, one output; resets to input.
// (R4) Wake pin as input is active high; as output, active-low open drain.
// (R5) Wake pin wakes the device from idle only while direction selects input.
// (R6) Full shutdown bit 2 turns off all regulators, power-on reset and bandgap.
// (R7) Regulator shutdown bit 1 turns off regulators and power-on reset, keeps bandgap.
// (R8) After shutdown, wake pin high or RTC alarm re-enables the circuits.
// (R9) Software uses shutdown only when internal regulators power the chip.
// (R10) Clock-out enable bit 0: zero disables, one enables; resets to zero.
// (R11) Core voltage select: zero gives 1.3 V, one gives 1.05 V.
// (R12) USB regulator enable: zero off and high impedance, one on at 1.3 V.
// (R13) USB enable reset value follows clock-source pin: high disables, low enables.
// (R14) Core regulator is off whenever its active-low enable pin is high.
// (R15) Clock-source pin low keeps USB regulator on unless a shutdown bit is set.
// (R16) Clock-out slew bit 2: zero slow, one fast; resets to one.
// (R17) External-memory slew bit 0: zero slow, one fast; resets to one.
// (R18) Serial pulldown inhibit bits 13:8 and 5:0: one disables pulldown; reset one.
// (R19) Test-reset pin pulldown is always enabled, no bit disables it.
// (R20) Fields take reset values on reset and update on the edge after a write.
package power_pad_pkg;

	localparam logic [15:0] RTC_POWER_MANAGEMENT_IDX    = 16'h1930;
	localparam logic [15:0] OUTPUT_SLEW_CONTROL_IDX     = 16'h1C16;
	localparam logic [15:0] SERIAL_PULLDOWN_INHIBIT_IDX = 16'h1C17;
	localparam logic [15:0] MISC_PULL_INHIBIT_IDX       = 16'h1C18;
	localparam logic [15:0] REGULATOR_CONTROL_IDX       = 16'h7004;

	localparam logic [15:0] RTC_POWER_MANAGEMENT_MASK    = 16'h001F;
	localparam logic [15:0] OUTPUT_SLEW_CONTROL_MASK     = 16'h0005;
	localparam logic [15:0] SERIAL_PULLDOWN_INHIBIT_MASK = 16'h3F3F;
	localparam logic [15:0] MISC_PULL_INHIBIT_MASK       = 16'hFFFF;
	localparam logic [15:0] REGULATOR_CONTROL_MASK       = 16'h0003;

	localparam logic [15:0] RTC_POWER_MANAGEMENT_RESET    = 16'h0010;
	localparam logic [15:0] OUTPUT_SLEW_CONTROL_RESET     = 16'h0005;
	localparam logic [15:0] SERIAL_PULLDOWN_INHIBIT_RESET = 16'h3F3F;
	localparam logic [15:0] MISC_PULL_INHIBIT_RESET       = 16'hF03F;
	localparam logic [15:0] REGULATOR_CONTROL_RESET       = 16'h0000;

	localparam int WAKE_PIN_DRIVE_BIT          = 4;
	localparam int WAKE_PIN_DIRECTION_BIT      = 3;
	localparam int FULL_ANALOG_SHUTDOWN_BIT    = 2;
	localparam int REGULATOR_SHUTDOWN_BIT      = 1;
	localparam int RTC_CLOCK_OUT_ENABLE_BIT    = 0;
	localparam int CLOCK_OUT_SLEW_SELECT_BIT   = 2;
	localparam int EXT_MEM_SLEW_SELECT_BIT     = 0;
	localparam int CORE_VOLTAGE_SELECT_BIT     = 1;
	localparam int USB_REGULATOR_ENABLE_BIT    = 0;

	localparam logic [31:0] UNMAPPED_READ_VALUE = 32'h0000_0000;

	typedef struct packed {
		logic analog_regulator_on;
		logic core_regulator_on;
		logic usb_regulator_on;
		logic analog_por_on;
		logic bandgap_on;
	} power_state_t;

	typedef struct packed {
		logic clock_out_slew_select;
		logic ext_mem_slew_select;
		logic test_reset_n_pin_pulldown_en;
		logic [15:0] serial_pulldown_inhibit;
		logic [15:0] misc_pull_inhibit;
	} pad_control_t;

	localparam power_state_t POWER_STATE_RESET = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
	localparam pad_control_t PAD_CONTROL_RESET = '{1'b1, 1'b1, 1'b1, 16'h3F3F, 16'hF03F};

endpackage : power_pad_pkg
